// ### rtl/dcas_controller.sv
// Host controller driving the random port of a multiport video DRAM
`timescale 1ns/1ps
`include "dcas_map.svh"
module dcas_controller #(
    parameter int PAUSE_CYC = `DCAS_WAKE_PAUSE_CYC,
    parameter int REF_INTERVAL_CYC = `DCAS_REF_INTERVAL_CYC,
    parameter int ADDR_W = 9
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [2*ADDR_W-1:0] reqAddr,
    input wire logic [3:0] reqWdata,
    output logic reqReady,
    output logic rspValid,
    output logic [3:0] rspRdata,
    output logic initDone,
    output logic wakeRetrigger,
    output logic rowStrobeN,
    output logic columnStrobeN,
    output logic maskWriteEnableN,
    output logic transferOutputEnableN,
    output logic [ADDR_W-1:0] addrPins,
    input wire logic [3:0] randomPortDataPinsIn,
    output logic [3:0] randomPortDataPinsOut,
    output logic randomPortDataPinsOe
);
    dcas_pkg::dcas_state_e state_ff;
    logic [19:0] wait_ff;
    logic [3:0] wakeCount_ff;
    logic [10:0] owed_ff;
    logic isWrite_ff;
    logic [2*ADDR_W-1:0] addr_ff;
    dcas_pkg::dcas_data_t wdata_ff;
    logic refTick;
    logic waitDone;

    function automatic logic [19:0] cyc(input int n);
        cyc = 20'((n < 1) ? 0 : n - 1);
    endfunction

    // Timer runs only once the device is awake
    dcas_interval_timer #(.INTERVAL(REF_INTERVAL_CYC)) uTimer (
        .clk(clk),
        .reset(reset),
        .enable(initDone),
        .tick(refTick)
    );

    assign waitDone = (wait_ff == 20'h00000);
    assign reqReady = (state_ff == dcas_pkg::ST_IDLE) && (owed_ff == 11'h000) && waitDone;
    // Owed refreshes beyond one row-set mean the period was overrun
    assign wakeRetrigger = (owed_ff > 11'(`DCAS_ROWS));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            owed_ff <= 11'h000;
        end else if (wakeRetrigger) begin
            owed_ff <= 11'h000;
        end else if (refTick && !(state_ff == dcas_pkg::ST_REF_RAS && waitDone)) begin
            owed_ff <= owed_ff + 11'h001;
        end else if (!refTick && state_ff == dcas_pkg::ST_REF_RAS && waitDone
                     && owed_ff != 11'h000) begin
            owed_ff <= owed_ff - 11'h001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= dcas_pkg::ST_PAUSE;
            wait_ff <= cyc(PAUSE_CYC);
            wakeCount_ff <= 4'h0;
            initDone <= 1'b0;
            isWrite_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 4'h0;
        end else if (wakeRetrigger) begin
            state_ff <= dcas_pkg::ST_WAKE_PRE;
            wait_ff <= cyc(`DCAS_RP_CYC);
            wakeCount_ff <= 4'h0;
            initDone <= 1'b0;
        end else if (!waitDone) begin
            wait_ff <= wait_ff - 20'h00001;
        end else begin
            case (state_ff)
                dcas_pkg::ST_PAUSE: begin
                    state_ff <= dcas_pkg::ST_WAKE_RAS;
                    wait_ff <= cyc(`DCAS_RAS_CYC);
                end
                dcas_pkg::ST_WAKE_RAS: begin
                    state_ff <= dcas_pkg::ST_WAKE_PRE;
                    wait_ff <= cyc(`DCAS_RP_CYC);
                    wakeCount_ff <= wakeCount_ff + 4'h1;
                end
                dcas_pkg::ST_WAKE_PRE: begin
                    if (wakeCount_ff == 4'(`DCAS_WAKE_CYCLES)) begin
                        state_ff <= dcas_pkg::ST_IDLE;
                        initDone <= 1'b1;
                    end else begin
                        state_ff <= dcas_pkg::ST_WAKE_RAS;
                        wait_ff <= cyc(`DCAS_RAS_CYC);
                    end
                end
                dcas_pkg::ST_IDLE: begin
                    if (owed_ff != 11'h000) begin
                        state_ff <= dcas_pkg::ST_REF_CAS;
                        wait_ff <= cyc(`DCAS_CSR_CYC);
                    end else if (reqValid) begin
                        state_ff <= dcas_pkg::ST_ROW;
                        wait_ff <= cyc(`DCAS_RCD_CYC);
                        isWrite_ff <= reqWrite;
                        addr_ff <= reqAddr;
                        wdata_ff <= reqWdata;
                    end
                end
                dcas_pkg::ST_ROW: begin
                    state_ff <= dcas_pkg::ST_COL;
                    wait_ff <= cyc(`DCAS_RAS_CYC);
                end
                dcas_pkg::ST_COL: begin
                    state_ff <= dcas_pkg::ST_END;
                    wait_ff <= cyc(`DCAS_OD_CYC);
                end
                dcas_pkg::ST_END: begin
                    state_ff <= dcas_pkg::ST_PRE;
                    wait_ff <= cyc(`DCAS_RP_CYC);
                end
                dcas_pkg::ST_PRE: begin
                    state_ff <= dcas_pkg::ST_IDLE;
                end
                dcas_pkg::ST_REF_CAS: begin
                    state_ff <= dcas_pkg::ST_REF_RAS;
                    wait_ff <= cyc(`DCAS_RAS_CYC + `DCAS_CHR_CYC);
                end
                dcas_pkg::ST_REF_RAS: begin
                    state_ff <= dcas_pkg::ST_PRE;
                    wait_ff <= cyc(`DCAS_RP_CYC);
                end
                default: begin
                    state_ff <= dcas_pkg::ST_PAUSE;
                end
            endcase
        end
    end

    // Pin drive, registered per state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rowStrobeN <= 1'b1;
            columnStrobeN <= 1'b1;
            maskWriteEnableN <= 1'b1;
            transferOutputEnableN <= 1'b1;
            addrPins <= '0;
            randomPortDataPinsOut <= 4'h0;
            randomPortDataPinsOe <= 1'b0;
        end else if (wakeRetrigger) begin
            // Overrun aborts the running cycle; strobes go idle for the new wake-up
            rowStrobeN <= 1'b1;
            columnStrobeN <= 1'b1;
            maskWriteEnableN <= 1'b1;
            transferOutputEnableN <= 1'b1;
            randomPortDataPinsOe <= 1'b0;
        end else begin
            rowStrobeN <= !(state_ff == dcas_pkg::ST_WAKE_RAS || state_ff == dcas_pkg::ST_ROW
                            || state_ff == dcas_pkg::ST_COL || state_ff == dcas_pkg::ST_REF_RAS);
            // Column low only after row, or ahead of row for refresh
            columnStrobeN <= !(state_ff == dcas_pkg::ST_COL || state_ff == dcas_pkg::ST_REF_CAS
                               || state_ff == dcas_pkg::ST_REF_RAS);
            // Write enable set before column falls: early write
            maskWriteEnableN <= !(isWrite_ff && (state_ff == dcas_pkg::ST_ROW
                                  || state_ff == dcas_pkg::ST_COL));
            // Output enable only in reads, released with the column strobe
            transferOutputEnableN <= !(!isWrite_ff && state_ff == dcas_pkg::ST_COL);
            // Row address set up as the request is taken and held past the row fall
            if (state_ff == dcas_pkg::ST_IDLE) begin
                addrPins <= reqAddr[2*ADDR_W-1:ADDR_W];
            end else if (state_ff == dcas_pkg::ST_ROW && waitDone) begin
                addrPins <= addr_ff[ADDR_W-1:0];
            end
            randomPortDataPinsOut <= wdata_ff;
            randomPortDataPinsOe <= isWrite_ff && (state_ff == dcas_pkg::ST_ROW
                                    || state_ff == dcas_pkg::ST_COL);
        end
    end

    // Read data sampled at the end of the column strobe, before it rises
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rspValid <= 1'b0;
            rspRdata <= 4'h0;
        end else begin
            rspValid <= 1'b0;
            if (state_ff == dcas_pkg::ST_COL && waitDone && !wakeRetrigger && !isWrite_ff) begin
                rspValid <= 1'b1;
                rspRdata <= randomPortDataPinsIn;
            end
        end
    end

    logic [3:0] highRun_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            highRun_ff <= 4'h0;
        end else if (!columnStrobeN) begin
            highRun_ff <= 4'h0;
        end else if (highRun_ff != 4'hF) begin
            highRun_ff <= highRun_ff + 4'h1;
        end
    end

    AST_CP_BEFORE_RAS: assert property (@(posedge clk) disable iff (reset)
        ($fell(rowStrobeN) && columnStrobeN) |-> highRun_ff >= 4'(`DCAS_CP_CYC))
        else $error("Column precharge too short before row strobe");
    AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (reset)
        !(randomPortDataPinsOe && !transferOutputEnableN))
        else $error("Output enable low while driving data");
    AST_EARLY_WRITE: assert property (@(posedge clk) disable iff (reset)
        ($fell(columnStrobeN) && !rowStrobeN) |-> $past(maskWriteEnableN) ? 1'b1 :
        randomPortDataPinsOe)
        else $error("Write data not driven at column fall");
    AST_CBR_ORDER: assert property (@(posedge clk) disable iff (reset)
        ($fell(rowStrobeN) && state_ff == dcas_pkg::ST_REF_RAS) |-> !columnStrobeN)
        else $error("Refresh row strobe without column low");
    AST_WAKE_COUNT: assert property (@(posedge clk) disable iff (reset)
        $rose(initDone) |-> wakeCount_ff == 4'(`DCAS_WAKE_CYCLES))
        else $error("Wake-up did not run eight row cycles");
    AST_READ_HOLD: assert property (@(posedge clk) disable iff (reset)
        rspValid |-> !columnStrobeN ##1 columnStrobeN)
        else $error("Read ended before column strobe rose");
    AST_OE_RELEASE: assert property (@(posedge clk) disable iff (reset)
        $rose(columnStrobeN) |-> transferOutputEnableN)
        else $error("Output enable not released with column strobe");
    AST_REF_SERVICE: assert property (@(posedge clk) disable iff (reset)
        (state_ff == dcas_pkg::ST_IDLE && owed_ff != 11'h000 && waitDone && !wakeRetrigger)
        |=> state_ff == dcas_pkg::ST_REF_CAS)
        else $error("Owed refresh not started");
    AST_RETRIGGER: assert property (@(posedge clk) disable iff (reset)
        wakeRetrigger |=> !initDone && state_ff == dcas_pkg::ST_WAKE_PRE)
        else $error("Overrun did not restart wake-up");
    AST_TICK_OWES: assert property (@(posedge clk) disable iff (reset)
        (refTick && state_ff == dcas_pkg::ST_IDLE && !wakeRetrigger) |=> owed_ff != 11'h000)
        else $error("Refresh tick lost");

    COV_READ: cover property (@(posedge clk) disable iff (reset) rspValid);
    COV_WRITE: cover property (@(posedge clk) disable iff (reset)
        $fell(columnStrobeN) && !maskWriteEnableN);
    COV_REFRESH: cover property (@(posedge clk) disable iff (reset)
        state_ff == dcas_pkg::ST_REF_RAS);
    COV_INIT: cover property (@(posedge clk) disable iff (reset) $rose(initDone));
endmodule

// ### rtl/dcas_map.svh
// Timing counts and row count for the DRAM random-port controller
`ifndef DCAS_MAP_SVH
`define DCAS_MAP_SVH
`define DCAS_CLK_PERIOD_PS 4000
`define DCAS_WAKE_PAUSE_US 100
`define DCAS_WAKE_PAUSE_CYC ((`DCAS_WAKE_PAUSE_US * 1000000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_WAKE_CYCLES 8
`define DCAS_ROWS 512
`define DCAS_REF_PERIOD_US 16700
`define DCAS_REF_PERIOD_CYC ((`DCAS_REF_PERIOD_US * 1000) / (`DCAS_CLK_PERIOD_PS / 1000))
`define DCAS_REF_INTERVAL_CYC (`DCAS_REF_PERIOD_CYC / `DCAS_ROWS)
`define DCAS_CP_NS 10
`define DCAS_CP_CYC ((`DCAS_CP_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_RAS_NS 80
`define DCAS_RAS_CYC ((`DCAS_RAS_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_RP_NS 60
`define DCAS_RP_CYC ((`DCAS_RP_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_RCD_NS 20
`define DCAS_RCD_CYC ((`DCAS_RCD_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_CAS_NS 20
`define DCAS_CAS_CYC ((`DCAS_CAS_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_CSR_NS 10
`define DCAS_CSR_CYC ((`DCAS_CSR_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_CHR_NS 30
`define DCAS_CHR_CYC ((`DCAS_CHR_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`define DCAS_OD_NS 10
`define DCAS_OD_CYC ((`DCAS_OD_NS * 1000 + `DCAS_CLK_PERIOD_PS - 1) / `DCAS_CLK_PERIOD_PS)
`endif

// ### rtl/dcas_pkg.sv
// Types for the DRAM random-port controller
package dcas_pkg;
    typedef enum logic [3:0] {
        ST_PAUSE = 4'h0,
        ST_WAKE_RAS = 4'h1,
        ST_WAKE_PRE = 4'h2,
        ST_IDLE = 4'h3,
        ST_ROW = 4'h4,
        ST_COL = 4'h5,
        ST_END = 4'h6,
        ST_PRE = 4'h7,
        ST_REF_CAS = 4'h8,
        ST_REF_RAS = 4'h9
    } dcas_state_e;
    typedef logic [3:0] dcas_data_t;
endpackage

// ### rtl/dcas_interval_timer.sv
// Refresh interval timer: one-cycle tick per row refresh slot
`timescale 1ns/1ps
`include "dcas_map.svh"
module dcas_interval_timer #(
    parameter int INTERVAL = `DCAS_REF_INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    output logic tick
);
    logic [23:0] count_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_ff <= 24'h000000;
        end else if (!enable || count_ff == 24'(INTERVAL - 1)) begin
            count_ff <= 24'h000000;
        end else begin
            count_ff <= count_ff + 24'h000001;
        end
    end
    assign tick = enable && (count_ff == 24'(INTERVAL - 1));
endmodule

// ### sim/dcas_dram_model.sv
// Behavioural model of the DRAM random port as seen from its controller
`timescale 1ns/1ps
module dcas_dram_model #(
    parameter real CP_NS = 10.0
) (
    input wire logic rowStrobeN,
    input wire logic columnStrobeN,
    input wire logic maskWriteEnableN,
    input wire logic transferOutputEnableN,
    input wire logic [8:0] addrPins,
    input wire logic [3:0] dataIn,
    output logic [3:0] dataOut,
    output logic dataDrive,
    output int refreshCount,
    output int badCount
);
    logic [3:0] mem [logic [17:0]];
    logic [8:0] rowLat;
    logic [8:0] colLat;
    logic [3:0] readLat;
    logic readCycle;
    realtime casRise;
    initial begin
        refreshCount = 0;
        badCount = 0;
        readCycle = 1'b0;
        readLat = 4'h0;
        casRise = 0;
    end
    always @(posedge columnStrobeN) begin
        casRise = $realtime;
        if (readCycle && maskWriteEnableN === 1'b0) badCount++;
    end
    always @(negedge rowStrobeN) begin
        if (columnStrobeN === 1'b0) begin
            refreshCount++;
        end else begin
            rowLat = addrPins;
            if ($realtime - casRise < CP_NS) badCount++;
        end
    end
    always @(negedge columnStrobeN) begin
        if (rowStrobeN === 1'b0) begin
            colLat = addrPins;
            readCycle = maskWriteEnableN;
            if (maskWriteEnableN === 1'b0) begin
                mem[{rowLat, addrPins}] = dataIn;
            end else begin
                readLat = mem.exists({rowLat, addrPins}) ? mem[{rowLat, addrPins}] : 4'h0;
            end
        end
    end
    // Late write with outputs still enabled would collide with the controller
    always @(negedge maskWriteEnableN) begin
        if (!columnStrobeN && !transferOutputEnableN) badCount++;
        // Write enable after column fall: late or read-write, data taken on this edge
        if (!rowStrobeN && !columnStrobeN) mem[{rowLat, colLat}] = dataIn;
    end
    // Old read data returns if output enable falls again while column stays low
    assign dataDrive = readCycle && !columnStrobeN && !transferOutputEnableN;
    // Released lines show the inverse of the last data, not a held value
    assign dataOut = dataDrive ? readLat : ~readLat;
endmodule

// ### sim/testbench.sv
// Self-checking bench for the DRAM random-port controller
`timescale 1ns/1ps
module testbench;
    localparam int PAUSE = 10;
    logic clk, reset, reset2, reqValid, reqWrite, reqReady, rspValid, initDone, wakeRetrigger;
    logic rasN, casN, weN, oeN, dqOe, modelDrive, ras2N, cas2N, retrig2;
    logic [17:0] reqAddr;
    logic [3:0] reqWdata, rspRdata, dqIn, dqOut, modelOut;
    logic [8:0] addrPins;
    int refreshCount, badCount;
    int numErrors = 0;
    int nChecks = 0;
    dcas_controller #(.PAUSE_CYC(PAUSE), .REF_INTERVAL_CYC(200)) dut (
        .clk(clk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
        .initDone(initDone), .wakeRetrigger(wakeRetrigger), .rowStrobeN(rasN),
        .columnStrobeN(casN), .maskWriteEnableN(weN), .transferOutputEnableN(oeN),
        .addrPins(addrPins), .randomPortDataPinsIn(dqIn), .randomPortDataPinsOut(dqOut),
        .randomPortDataPinsOe(dqOe));
    dcas_controller #(.PAUSE_CYC(PAUSE), .REF_INTERVAL_CYC(20)) dut2 (
        .clk(clk), .reset(reset2), .reqValid(1'b0), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .reqReady(), .rspValid(), .rspRdata(), .initDone(),
        .wakeRetrigger(retrig2), .rowStrobeN(ras2N), .columnStrobeN(cas2N),
        .maskWriteEnableN(), .transferOutputEnableN(), .addrPins(),
        .randomPortDataPinsIn(dqIn), .randomPortDataPinsOut(), .randomPortDataPinsOe());
    dcas_dram_model model (
        .rowStrobeN(rasN), .columnStrobeN(casN), .maskWriteEnableN(weN),
        .transferOutputEnableN(oeN), .addrPins(addrPins), .dataIn(dqOut), .dataOut(modelOut),
        .dataDrive(modelDrive), .refreshCount(refreshCount), .badCount(badCount));
    assign dqIn = (dqOe && !modelDrive) ? dqOut : modelOut;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        numErrors++;
        $display("unexpected wait on %s: expected event, seen none", what);
        report_and_stop();
    endtask
    // Data lines must never be driven by both ends; writes keep outputs disabled
    always @(negedge clk) begin
        if (!reset && initDone === 1'b1) begin
            check("both ends driving", 0, modelDrive && dqOe);
            check("overrun flag", 0, wakeRetrigger);
            if (weN === 1'b0 && casN === 1'b0) check("enable during write", 1, oeN);
        end
    end
    task automatic do_req(input logic wr, input logic [17:0] a, input logic [3:0] d);
        int n = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 5000);
        if (n >= 5000) timeout("request accept");
        @(posedge clk);
        reqValid <= 1'b0;
    endtask
    task automatic do_read(input logic [17:0] a, input logic [3:0] exp);
        int n = 0;
        do_req(1'b0, a, 4'h0);
        while (rspValid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) timeout("read answer");
        check("read data", exp, rspRdata);
    endtask
    task automatic test_wakeup;
        int cyc = 0;
        int falls = 0;
        logic prev = 1'b1;
        while (initDone !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
            if (prev && rasN === 1'b0) begin
                if (falls == 0) check("pause before wake", 1, cyc >= PAUSE);
                falls++;
            end
            if (initDone !== 1'b1) check("ready before wake", 0, reqReady);
            prev = rasN;
        end
        check("wake row cycles", 8, falls);
        check("refreshes during wake", 0, refreshCount);
        $display("wake-up test done");
    endtask
    task automatic test_write_read;
        logic [17:0] addrs [4] = '{18'h00000, 18'h3FFFF, 18'h1FE01, 18'h00155};
        for (int i = 0; i < 4; i++) do_req(1'b1, addrs[i], 4'(i * 5 + 3));
        do_req(1'b1, addrs[1], 4'hA);
        do_read(addrs[1], 4'hA);
        for (int i = 0; i < 4; i += 2) do_read(addrs[i], 4'(i * 5 + 3));
        do_read(addrs[3], 4'h2);
        $display("write and read test done");
    endtask
    task automatic test_refresh;
        int start = refreshCount;
        repeat (2000) @(posedge clk);
        check("refreshes in ten slots", 1, (refreshCount - start) inside {[9:11]});
        $display("refresh test done");
    endtask
    task automatic test_overrun;
        int n = 0;
        int falls = 0;
        logic prev;
        reset2 <= 1'b0;
        while (retrig2 !== 1'b1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60000) timeout("overrun flag");
        prev = ras2N;
        for (n = 0; n < 2000; n++) begin
            @(negedge clk);
            if (prev && ras2N === 1'b0) begin
                if (cas2N === 1'b0) break;
                falls++;
            end
            prev = ras2N;
        end
        check("row cycles after overrun", 8, falls);
        $display("overrun test done");
    endtask
    initial begin
        reset = 1'b1;
        reset2 = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 18'h00000;
        reqWdata = 4'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        test_wakeup();
        test_write_read();
        test_refresh();
        test_overrun();
        check("strobe timing faults", 0, badCount);
        report_and_stop();
    end
endmodule
